// file: hw/cets_pkg.sv
// Package for the camera exposure trigger sequencer: register map, field
// positions, reset values, modes and the sequencer states.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one clock.
package cets_pkg;

    // Register byte offsets
    localparam logic [4:0] CTRL_OFF     = 5'h00;
    localparam logic [4:0] CONFIG_OFF   = 5'h04;
    localparam logic [4:0] FRAMES_OFF   = 5'h08;
    localparam logic [4:0] EXPOSURE_OFF = 5'h0C;
    localparam logic [4:0] INTERVAL_OFF = 5'h10;
    localparam logic [4:0] STATUS_OFF   = 5'h14;
    localparam logic [4:0] COUNTS_OFF   = 5'h18;

    // Control register bits
    localparam int CTRL_ARM_BIT     = 0;
    localparam int CTRL_CAPTURE_BIT = 1;
    localparam int CTRL_HALT_BIT    = 2;

    // Configuration register fields
    localparam int CFG_SRC_LSB  = 0;
    localparam int CFG_EDGE_BIT = 4;

    // Status register fields
    localparam int STAT_STATE_LSB  = 0;
    localparam int STAT_BUSY_BIT   = 4;
    localparam int STAT_ARMED_BIT  = 5;
    localparam int STAT_TRIG_BIT   = 6;
    localparam int STAT_STROBE_BIT = 7;

    // Reset values; times are in clock cycles of the 25 MHz clock
    localparam logic [15:0] FRAMES_RST   = 16'h0001;
    localparam logic [31:0] EXPOSURE_RST = 32'h0000_0019;
    localparam logic [31:0] INTERVAL_RST = 32'h0000_0064;

    // Trigger source selection
    typedef enum logic [1:0] {
        CETS_SRC_NONE     = 2'b00,
        CETS_SRC_STANDARD = 2'b01,
        CETS_SRC_PULSE    = 2'b10
    } cets_src_t;

    // Sequencer states
    typedef enum logic [1:0] {
        CETS_ST_IDLE    = 2'b00,
        CETS_ST_EXPOSE  = 2'b01,
        CETS_ST_READOUT = 2'b10,
        CETS_ST_WAIT    = 2'b11
    } cets_state_t;

    // Host-written settings that steer the sequencer
    typedef struct packed {
        cets_src_t   trigger_source_select;
        logic        trigger_edge_select;    // 1: rising edge / active high
        logic [15:0] frames;
        logic [31:0] exposure;
        logic [31:0] interval;
    } cets_cfg_t;

endpackage : cets_pkg

// file: hw/cets_top.sv
// Camera exposure trigger sequencer: trigger synchroniser, mode decode,
// exposure / readout sequencer and an Avalon-MM register slave.
// Assumes a single clock, a readout path that answers readout_start with
// a readout_done pulse, and a trigger input with no timing relation to clk.
//
// Contract
// R1 - Streaming: trigger starts repeating expose, readout cycles
// R2 - Streaming: later triggers ignored until halted
// R3 - Async: each trigger gives one timed exposure, readout
// R4 - Async: triggers during readout are ignored
// R5 - Async: after readout, idle until next trigger
// R6 - Pulse mode: trigger level sets exposure length
// R7 - Pulse mode: triggers during readout are ignored
// R8 - Strobe output high throughout each exposure
// R9 - Source none: capture command takes frame count
// R10 - Standard source, frames zero or above one: streaming
// R11 - Standard source, frames exactly one: async
// R12 - Pulse source selects pulse-driven exposure
// R13 - Polarity picks rising or falling active edge
// R14 - Trigger behaviour independent of readout settings
// R15 - Synchronise trigger, detect edge after synchroniser
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module cets_top (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Trigger pin and exposure indicator
    input  wire logic        trigger_in,
    output logic             strobe_out,
    // Readout path
    output logic             readout_start,
    input  wire logic        readout_done
);

    // Registers
    logic                  arm_reg;
    logic                  capture_reg;
    logic                  halt_reg;
    cets_pkg::cets_cfg_t   cfg_reg;
    cets_pkg::cets_state_t state_reg;
    cets_pkg::cets_state_t state_next;
    logic [31:0]           exp_cnt_reg;
    logic [31:0]           ivl_cnt_reg;
    logic [15:0]           frame_cnt_reg;
    logic [15:0]           ignored_cnt_reg;
    logic [15:0]           done_cnt_reg;
    logic                  strobe_reg;
    logic                  rdo_start_reg;
    logic                  ack_reg;
    logic [31:0]           rdata_reg;
    logic [2:0]            sync_reg;

    // Merge write data into a word under the byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // Bus decode: one wait state, then the access completes. A read is
    // latched on the first edge so its data stand at the completing edge;
    // a write lands only at the completing edge, where waitrequest is low,
    // so a master that has not yet seen the answer has changed nothing.
    wire bus_req    = avs_read | avs_write;
    wire bus_fire   = ce & bus_req & ~ack_reg;
    wire wr_fire    = ce & avs_write & ack_reg;
    wire [4:0] woff = {avs_address[4:2], 2'b00};
    wire wr_ctrl    = wr_fire & (woff == cets_pkg::CTRL_OFF);
    wire wr_cfg     = wr_fire & (woff == cets_pkg::CONFIG_OFF);
    wire wr_frames  = wr_fire & (woff == cets_pkg::FRAMES_OFF);
    wire wr_exp     = wr_fire & (woff == cets_pkg::EXPOSURE_OFF);
    wire wr_ivl     = wr_fire & (woff == cets_pkg::INTERVAL_OFF);
    wire [31:0] ctrl_word = {29'h0, halt_reg, capture_reg, arm_reg};
    wire [31:0] ctrl_new  = be_merge(ctrl_word, avs_writedata, avs_byteenable);
    wire [31:0] cfg_word  = {27'h0, cfg_reg.trigger_edge_select, 2'b00,
                             cfg_reg.trigger_source_select};
    wire [31:0] cfg_new   = be_merge(cfg_word, avs_writedata, avs_byteenable);
    wire [31:0] frm_new   = be_merge({16'h0, cfg_reg.frames}, avs_writedata,
                                     avs_byteenable);
    wire [31:0] exp_new   = be_merge(cfg_reg.exposure, avs_writedata,
                                     avs_byteenable);
    wire [31:0] ivl_new   = be_merge(cfg_reg.interval, avs_writedata,
                                     avs_byteenable);

    assign avs_waitrequest = bus_req & ~ack_reg;
    assign avs_readdata    = rdata_reg;

    // Trigger qualification from the last synchroniser stage only
    // Stage 2 is only the edge reference, so a metastable stage 0 never counts
    wire trig_sync   = sync_reg[1];
    wire act_now     = cfg_reg.trigger_edge_select ? trig_sync : ~trig_sync;  // see R13
    wire act_prev    = cfg_reg.trigger_edge_select ? sync_reg[2] : ~sync_reg[2];
    wire trig_edge   = act_now & ~act_prev;                                   // see R15

    // Mode decode; only source and frame count matter, nothing else
    // Readout rate, binning, gain and offset deliberately never enter here
    wire src_none    = cfg_reg.trigger_source_select == cets_pkg::CETS_SRC_NONE;
    wire src_std     = cfg_reg.trigger_source_select == cets_pkg::CETS_SRC_STANDARD;
    wire mode_pulse  = cfg_reg.trigger_source_select == cets_pkg::CETS_SRC_PULSE; // see R12
    wire mode_async  = src_std & (cfg_reg.frames == 16'h0001);                // see R11
    wire mode_stream = src_std & (cfg_reg.frames != 16'h0001);                // see R10, R14
    wire repeating   = mode_stream | src_none;

    // Start conditions out of idle
    // A level already present when arming is no start: only a fresh edge
    wire trig_start  = arm_reg & ~src_none & trig_edge;                       // see R1, R3, R6
    wire sw_start    = src_none & capture_reg;                                // see R9
    wire start       = trig_start | sw_start;

    // End-of-phase conditions
    // Exposure values 0 and 1 both give one cycle; the count cannot go lower
    wire exp_over    = mode_pulse ? ~act_now                                  // see R6
                                  : (exp_cnt_reg <= 32'h0000_0001);           // see R1, R3
    wire ivl_over    = ivl_cnt_reg >= cfg_reg.interval;
    wire last_frame  = (cfg_reg.frames != 16'h0000) &
                       (frame_cnt_reg >= cfg_reg.frames);
    wire stop_req    = halt_reg | ~(arm_reg | src_none);
    wire busy        = state_reg != cets_pkg::CETS_ST_IDLE;

    // Edges that arrive while busy are counted, except with source none, and otherwise dropped
    // Counting them lets software see how many external triggers were lost
    wire trig_drop   = busy & trig_edge & ~src_none;                          // see R2, R4, R7

    // Sequencer next state
    // WAIT only paces repeats; async and pulse frames never enter it
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cets_pkg::CETS_ST_IDLE: begin
                if (start) begin
                    state_next = cets_pkg::CETS_ST_EXPOSE;
                end
            end
            cets_pkg::CETS_ST_EXPOSE: begin
                if (exp_over) begin
                    state_next = cets_pkg::CETS_ST_READOUT;
                end
            end
            cets_pkg::CETS_ST_READOUT: begin
                if (readout_done) begin
                    // One readout per trigger in async and pulse modes
                    if (repeating & ~last_frame & ~stop_req) begin     // see R1
                        state_next = cets_pkg::CETS_ST_WAIT;
                    end else begin
                        state_next = cets_pkg::CETS_ST_IDLE;                  // see R5
                    end
                end
            end
            cets_pkg::CETS_ST_WAIT: begin
                if (stop_req) begin
                    state_next = cets_pkg::CETS_ST_IDLE;                      // see R2
                end else if (ivl_over) begin
                    state_next = cets_pkg::CETS_ST_EXPOSE;                    // see R1
                end
            end
            default: begin
                state_next = cets_pkg::CETS_ST_IDLE;
            end
        endcase
    end

    wire enter_exp  = (state_next == cets_pkg::CETS_ST_EXPOSE) &
                      (state_reg != cets_pkg::CETS_ST_EXPOSE);
    wire enter_rdo  = (state_next == cets_pkg::CETS_ST_READOUT) &
                      (state_reg != cets_pkg::CETS_ST_READOUT);

    // Trigger synchroniser; stage 0 feeds only stage 1
    // ce low holds it as well, so a pulse shorter than the freeze is lost
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync_reg <= 3'h0;
        end else if (ce) begin
            sync_reg <= {sync_reg[1:0], trigger_in};                          // see R15
        end
    end

    // Sequencer state, timers and counters
    // The interval counter stops once over, so a long readout cannot wrap it
    // Ignored and done counts wrap; software works with differences
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg       <= cets_pkg::CETS_ST_IDLE;
            exp_cnt_reg     <= 32'h0000_0000;
            ivl_cnt_reg     <= 32'h0000_0000;
            frame_cnt_reg   <= 16'h0000;
            ignored_cnt_reg <= 16'h0000;
            done_cnt_reg    <= 16'h0000;
            strobe_reg      <= 1'b0;
            rdo_start_reg   <= 1'b0;
        end else if (ce) begin
            state_reg     <= state_next;
            strobe_reg    <= state_next == cets_pkg::CETS_ST_EXPOSE;          // see R8
            rdo_start_reg <= enter_rdo;
            exp_cnt_reg   <= enter_exp ? cfg_reg.exposure
                                       : exp_cnt_reg - {31'h0, exp_cnt_reg != 32'h0};
            // Interval runs from one exposure start to the next
            ivl_cnt_reg   <= enter_exp ? 32'h0000_0001
                                       : ivl_cnt_reg + {31'h0, ~ivl_over};
            if (state_reg == cets_pkg::CETS_ST_IDLE && start) begin
                frame_cnt_reg <= 16'h0001;
            end else if (enter_exp) begin
                frame_cnt_reg <= frame_cnt_reg + 16'h0001;
            end
            if (trig_drop) begin
                ignored_cnt_reg <= ignored_cnt_reg + 16'h0001;
            end
            if (state_reg == cets_pkg::CETS_ST_READOUT && readout_done) begin
                done_cnt_reg <= done_cnt_reg + 16'h0001;
            end
        end
    end

    assign strobe_out    = strobe_reg;
    assign readout_start = rdo_start_reg;

    // Control and configuration registers; capture and halt self-clear
    // once the sequencer has seen them, so a late write is never lost
    always_ff @(posedge clk) begin
        if (!resetn) begin
            arm_reg     <= 1'b0;
            capture_reg <= 1'b0;
            halt_reg    <= 1'b0;
            cfg_reg     <= '{trigger_source_select: cets_pkg::CETS_SRC_NONE,
                             trigger_edge_select:   1'b0,
                             frames:   cets_pkg::FRAMES_RST,
                             exposure: cets_pkg::EXPOSURE_RST,
                             interval: cets_pkg::INTERVAL_RST};
        end else if (ce) begin
            if (wr_ctrl) begin
                arm_reg     <= ctrl_new[cets_pkg::CTRL_ARM_BIT];
                capture_reg <= ctrl_new[cets_pkg::CTRL_CAPTURE_BIT];
                halt_reg    <= ctrl_new[cets_pkg::CTRL_HALT_BIT];
            end else begin
                // Capture is consumed on start; halt once back in idle
                capture_reg <= capture_reg & ~(sw_start & ~busy);
                halt_reg    <= halt_reg & busy;
            end
            if (wr_cfg) begin
                cfg_reg.trigger_source_select <=
                    cets_pkg::cets_src_t'(cfg_new[cets_pkg::CFG_SRC_LSB +: 2]);
                cfg_reg.trigger_edge_select <= cfg_new[cets_pkg::CFG_EDGE_BIT];
            end
            if (wr_frames) begin
                cfg_reg.frames <= frm_new[15:0];
            end
            if (wr_exp) begin
                cfg_reg.exposure <= exp_new;
            end
            if (wr_ivl) begin
                cfg_reg.interval <= ivl_new;
            end
        end
    end

    // Read mux; unmapped offsets read as zero
    // The read is latched on the taking edge, so the mux may change after it
    wire [31:0] status_word = {24'h0, strobe_reg, trig_sync, arm_reg, busy,
                               2'b00, state_reg};
    logic [31:0] rd_mux;
    always_comb begin
        case (woff)
            cets_pkg::CTRL_OFF:     rd_mux = ctrl_word;
            cets_pkg::CONFIG_OFF:   rd_mux = cfg_word;
            cets_pkg::FRAMES_OFF:   rd_mux = {16'h0, cfg_reg.frames};
            cets_pkg::EXPOSURE_OFF: rd_mux = cfg_reg.exposure;
            cets_pkg::INTERVAL_OFF: rd_mux = cfg_reg.interval;
            cets_pkg::STATUS_OFF:   rd_mux = status_word;
            cets_pkg::COUNTS_OFF:   rd_mux = {ignored_cnt_reg, done_cnt_reg};
            default:                rd_mux = 32'h0000_0000;
        endcase
    end

    // Bus handshake: first edge latches data, second edge completes
    // ack_reg blocks a second take while the master still holds the request
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            ack_reg <= bus_fire;
            if (bus_fire && avs_read) begin
                rdata_reg <= rd_mux;
            end
        end
    end

endmodule : cets_top

`default_nettype wire

// file: testbench/cets_top_asserts.sv
// Checker for the trigger sequencer: bus handshake and exposure order.
// Assumes ce only drops while the bus is quiet; bound to cets_top.
`timescale 1ns/1ps
`default_nettype none
module cets_asserts (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        strobe_out,
    input wire logic        readout_start,
    input wire logic        readout_done
);
    logic in_ro_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Readout window; the done pulse only counts inside it
    always_ff @(posedge clk) begin
        if (!resetn) in_ro_reg <= 1'b0;
        else if (readout_start) in_ro_reg <= 1'b1;
        else if (readout_done) in_ro_reg <= 1'b0;
    end
    property p_ro_pulse; readout_start |=> !readout_start; endproperty
    a_ro_pulse: assert property (p_ro_pulse) else $error("readout start too long");
    property p_ro_after_exp; readout_start |-> $past(strobe_out) && !strobe_out; endproperty
    a_ro_after_exp: assert property (p_ro_after_exp) else $error("readout not after exposure");
    property p_exp_ends; $fell(strobe_out) |-> readout_start; endproperty
    a_exp_ends: assert property (p_exp_ends) else $error("exposure without readout");
    property p_dark_ro; in_ro_reg |-> !strobe_out; endproperty
    a_dark_ro: assert property (p_dark_ro) else $error("strobe during readout");
    property p_done_idle; in_ro_reg && readout_done |=> !strobe_out && !readout_start; endproperty
    a_done_idle: assert property (p_done_idle) else $error("no idle after readout");
    property p_one_wait;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait state not one cycle");
    property p_idle_nowait; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
    a_idle_nowait: assert property (p_idle_nowait) else $error("wait without request");
    property p_rd_hold; !(avs_read && avs_waitrequest) |=> $stable(avs_readdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    // Main scenarios reached
    c_ro: cover property (readout_start);
    c_exp: cover property ($rose(strobe_out));
    c_done: cover property (in_ro_reg && readout_done);
endmodule : cets_asserts
`default_nettype wire

// file: testbench/cets_trig_model.sv
// Trigger source and readout path facing the sequencer.
// Assumes the bench calls fire() just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module cets_trig_model (
    input  wire logic clk,
    input  wire logic edge_hi,
    input  wire logic readout_start,
    output logic      trigger_in,
    output logic      readout_done
);
    int   ro_delay = 30;
    int   ro_cnt   = 0;
    logic act      = 1'b0;
    // Idle at the inactive level of the chosen polarity
    assign trigger_in = act ? edge_hi : ~edge_hi;
    // Pulse width sets exposure length in pulse mode
    task automatic fire(input int width);
        act <= 1'b1;
        repeat (width) @(posedge clk);
        act <= 1'b0;
    endtask : fire
    // Readout path: done ro_delay cycles after each start, slow or prompt
    initial readout_done = 1'b0;
    always @(posedge clk) begin
        readout_done <= 1'b0;
        if (readout_start) ro_cnt <= ro_delay;
        else if (ro_cnt > 0) begin
            ro_cnt       <= ro_cnt - 1;
            readout_done <= (ro_cnt == 1);
        end
    end
endmodule : cets_trig_model
`default_nettype wire

// file: testbench/cets_top_tb_top.sv
// Bench for the trigger sequencer: reset values and every trigger mode.
// Assumes the checker and trigger model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module cets_top_tb_top;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdata;
    logic [31:0] v;
    logic        wreq, strobe, ro_start, ro_done, trig;
    logic        edge_hi = 1'b0;
    logic        ce = 1'b1;
    logic [3:0]  be = 4'hf;
    logic        st_q = 1'b0;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          n_exp = 0, cur = 0, exp_len = 0, cyc = 0, last = 0, gap = 0, c0;
    always #20 clk = ~clk;
    cets_top dut (.clk(clk), .resetn(resetn), .ce(ce), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(wreq), .trigger_in(trig),
        .strobe_out(strobe), .readout_start(ro_start), .readout_done(ro_done));
    cets_trig_model tm (.clk(clk), .edge_hi(edge_hi), .readout_start(ro_start),
        .trigger_in(trig), .readout_done(ro_done));
    // Count exposures, last length and start-to-start spacing
    always @(posedge clk) begin
        cyc  <= cyc + 1;
        st_q <= strobe;
        cur  <= strobe ? cur + 1 : 0;
        if (!strobe && st_q) exp_len <= cur;
        if (strobe && !st_q) begin
            n_exp <= n_exp + 1;
            gap   <= cyc - last;
            last  <= cyc;
        end
    end
    function automatic int f_len(input int ex);
        return (ex < 2) ? 1 : ex;
    endfunction : f_len
    // Byte lanes with their enable set replace the stored lanes
    function automatic logic [31:0] f_merge(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] m);
        for (int i = 0; i < 4; i++) begin
            if (m[i]) o[i*8 +: 8] = n[i*8 +: 8];
        end
        return o;
    endfunction : f_merge
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wd  <= d;
        wr  <= w;
        rd  <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        v = rdata;
        if (n >= 50) chk("waitrequest", 0, wreq);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus
    // Poll status until the sequencer is idle
    task automatic settle();
        int n;
        n = 0;
        repeat (4) @(posedge clk);
        do begin
            bus(0, cets_pkg::STATUS_OFF, 32'h0000_0000);
            n++;
        end while (v[1:0] !== 2'b00 && n < 200);
        if (n >= 200) chk("idle", 0, v);
    endtask : settle
    // Disarm, program a mode, then arm
    task automatic setup(input int src, e, fr, ex, iv);
        edge_hi <= e[0];
        bus(1, cets_pkg::CTRL_OFF, 32'h0000_0000);
        bus(1, cets_pkg::CONFIG_OFF, (32'(e[0]) << cets_pkg::CFG_EDGE_BIT) | 32'(src));
        bus(1, cets_pkg::FRAMES_OFF, 32'(fr));
        bus(1, cets_pkg::EXPOSURE_OFF, 32'(ex));
        bus(1, cets_pkg::INTERVAL_OFF, 32'(iv));
        bus(1, cets_pkg::CTRL_OFF, 32'h0000_0001);
        c0 = n_exp;
    endtask : setup
    // Trigger, a trigger during slow readout, then a fresh trigger
    task automatic one_shot(input int fa, input int elen);
        logic [31:0] base;
        tm.ro_delay = $urandom_range(30, 40);
        bus(0, cets_pkg::COUNTS_OFF, 32'h0000_0000);
        base = v;
        tm.fire(fa);
        repeat (20) @(posedge clk);
        tm.fire(2);
        settle();
        chk("exposure length", elen, exp_len);
        chk("exposures", c0 + 1, n_exp);
        bus(0, cets_pkg::COUNTS_OFF, 32'h0000_0000);
        chk("ignored and done", base + 32'h0001_0001, v);
        tm.fire(2);
        settle();
        chk("exposures", c0 + 2, n_exp);
    endtask : one_shot
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    // Watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        results();
    end
    initial begin
        logic [4:0]  ra [5] = '{5'h08, 5'h0C, 5'h10, 5'h04, 5'h1C};
        logic [31:0] rv [5] = '{32'h0000_0001, 32'h0000_0019, 32'h0000_0064,
                               32'h0000_0000, 32'h0000_0000};
        int          w;
        logic [3:0]  bm;
        logic [31:0] wdat;
        void'($urandom(78739));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        foreach (ra[i]) begin
            bus(0, ra[i], 32'h0000_0000);
            chk("reset value", rv[i], v);
        end
        bm   = 4'($urandom_range(1, 14));
        wdat = $urandom;
        be <= bm;
        bus(1, cets_pkg::EXPOSURE_OFF, wdat);
        be <= 4'hf;
        bus(0, cets_pkg::EXPOSURE_OFF, 32'h0000_0000);
        chk("lane merge", f_merge(cets_pkg::EXPOSURE_RST, wdat, bm), v);
        $display("done reset values");
        for (int e = 0; e < 2; e++) begin
            w = $urandom_range(2, 12);
            setup(1, e, 1, w, 100);
            one_shot(3, f_len(w));
            w = $urandom_range(3, 12);
            setup(2, 1 - e, 1, 25, 100);
            one_shot(w, w);
        end
        // Freezing ce mid-exposure stretches it by the frozen edges
        setup(1, 1, 1, 10, 100);
        tm.fire(3);
        repeat (2) @(posedge clk);
        w = $urandom_range(2, 6);
        ce <= 1'b0;
        repeat (w) @(posedge clk);
        ce <= 1'b1;
        settle();
        chk("frozen length", 10 + w, exp_len);
        $display("done single and pulse modes");
        tm.ro_delay = 1;
        setup(1, $urandom_range(0, 1), 3, 5, 40);
        tm.fire(2);
        repeat (60) @(posedge clk);
        tm.fire(2);
        settle();
        chk("stream frames", c0 + 3, n_exp);
        chk("stream interval", 40, gap);
        chk("stream length", 5, exp_len);
        setup(1, $urandom_range(0, 1), 0, 5, 40);
        tm.fire(2);
        repeat (300) @(posedge clk);
        chk("free run", 1, (n_exp - c0) >= 7);
        bus(1, cets_pkg::CTRL_OFF, 32'h0000_0005);
        settle();
        c0 = n_exp;
        repeat (100) @(posedge clk);
        chk("halted", c0, n_exp);
        $display("done streaming");
        setup(0, $urandom_range(0, 1), 2, 5, 40);
        tm.fire(2);
        repeat (20) @(posedge clk);
        chk("trigger ignored", c0, n_exp);
        bus(1, cets_pkg::CTRL_OFF, 32'h0000_0003);
        settle();
        chk("capture frames", c0 + 2, n_exp);
        $display("done software capture");
        results();
    end
endmodule : cets_top_tb_top
bind cets_top cets_asserts u_chk (.clk(clk), .resetn(resetn), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .strobe_out(strobe_out), .readout_start(readout_start), .readout_done(readout_done));
`default_nettype wire
